// ==== rtl/atf_ctrl.sv ====
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
// Operation
// R1 - Bits 31..16 of the control word read zero; writes ignored.
// R2 - Reorder-disable bit set stops out-of-order transmit pipelining; resets zero.
// R3 - Software keeps bit 14 zero; it resets to zero.
// R4 - Start-level codes 0..3 select 2K, 1.7K, 1K, 512 bytes.
// R5 - Start-level field resets to code one, 1.7K bytes.
// R6 - Programmed level is used only until the first underrun.
// R7 - A retried packet uses 2K threshold, store-and-forward.
// R8 - Below 2K, start at level or on whole packet, whichever first.
// R9 - FIFO emptying mid-packet before its end is an underrun.
// R10 - After underrun, retransmit only once the whole packet is in.
// R11 - At 2K nothing is sent before the end-of-packet token arrives.
// R12 - Retries register zero forces store-and-forward.
// R13 - Software should normally keep the 1.7K setting.
// R14 - All writable fields return to defaults on reset.
// R15 - Enhancement bits only act while the gate bit is set.
// R16 - Count bytes checked in per packet; compare with threshold.
module atf_ctrl import atf_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_CHK_BYTE,
  input wire logic I_CHK_EOP,
  input wire logic I_FIFO_EMPTY,
  input wire logic I_TX_DONE,
  input wire logic I_RETRY,
  output logic O_TX_START,
  output logic O_TX_ACTIVE,
  output logic O_UNDERRUN,
  output logic O_REORDER_EN
);
  logic reorder_dis;
  logic rsvd14;
  logic [1:0] thresh;
  logic [3:0] retries;
  logic gate;
  logic [31:0] status;
  logic saf;
  logic [CNT_W-1:0] level;
  atf_state_e state_r;
  logic [CNT_W-1:0] count_r;
  logic eop_r;
  logic underran_r;
  logic retry_r;
  logic start;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  atf_wb_slave u_wb (
    .i_clk(I_CLK),
    .i_rst(I_SRST), // R14
    .i_cyc(I_WB_CYC),
    .i_stb(I_WB_STB),
    .i_we(I_WB_WE),
    .i_adr(I_WB_ADR),
    .i_sel(I_WB_SEL),
    .i_dat(I_WB_DAT),
    .i_status(status),
    .o_dat(O_WB_DAT),
    .o_ack(O_WB_ACK),
    .o_reorder_dis(reorder_dis),
    .o_rsvd14(rsvd14),
    .o_thresh(thresh),
    .o_retries(retries),
    .o_gate(gate)
  );

  assign status = {16'h0, count_r[11:0], 1'b0, underran_r, retry_r, eop_r};

  // ----------------------------------------
  // Threshold choice
  // ----------------------------------------
  // Without the gate the enhancement is off, so fall back to the safe mode
  assign saf = !gate || underran_r || retry_r || (retries == 4'h0); // R6 R7 R12 R15
  atf_level_sel u_lvl (
    .i_code(thresh),
    .i_saf(saf),
    .o_level(level)
  );

  // Level reached or whole packet in; 2K level is never hit before EOP
  assign start = eop_r || (!saf && thresh != THR_SAF && count_r >= level); // R8 R10 R11

  // ----------------------------------------
  // Packet byte count
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SRST || (state_r == ATF_SEND && I_TX_DONE)) begin
      count_r <= '0;
      eop_r <= 1'b0;
    end else if (I_CHK_BYTE) begin
      if (count_r != {CNT_W{1'b1}}) begin
        count_r <= count_r + 1'b1; // R16
      end
      if (I_CHK_EOP) begin
        eop_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Underrun and retry memory
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      underran_r <= 1'b0;
      retry_r <= 1'b0;
    end else begin
      if (state_r == ATF_SEND && I_FIFO_EMPTY && !eop_r && !I_TX_DONE) begin
        underran_r <= 1'b1; // R6 R9
      end
      if (I_RETRY) begin
        retry_r <= 1'b1; // R7
      end else if (state_r == ATF_SEND && I_TX_DONE) begin
        retry_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmit state
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_r <= ATF_IDLE;
      O_TX_START <= 1'b0;
      O_TX_ACTIVE <= 1'b0;
      O_UNDERRUN <= 1'b0;
    end else begin
      O_TX_START <= 1'b0;
      O_UNDERRUN <= 1'b0;
      unique case (state_r)
        ATF_IDLE: begin
          if (I_CHK_BYTE) begin
            state_r <= ATF_FILL;
          end
        end
        ATF_FILL: begin
          if (start) begin
            state_r <= ATF_SEND;
            O_TX_START <= 1'b1;
            O_TX_ACTIVE <= 1'b1;
          end
        end
        ATF_SEND: begin
          if (I_TX_DONE) begin
            state_r <= ATF_IDLE;
            O_TX_ACTIVE <= 1'b0;
          end else if (I_FIFO_EMPTY && !eop_r) begin
            state_r <= ATF_FILL; // R9 R10
            O_TX_ACTIVE <= 1'b0;
            O_UNDERRUN <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_REORDER_EN <= 1'b1;
    end else begin
      O_REORDER_EN <= !(gate && reorder_dis); // R2 R15
    end
  end
endmodule : atf_ctrl

// ==== rtl/atf_pkg.sv ====
package atf_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] LEC_OFFSET = 8'hf4;
  localparam logic [7:0] STAT_OFFSET = 8'hf0;
  localparam logic [7:0] RETRY_OFFSET = 8'hec;
  localparam logic [7:0] GATE_OFFSET = 8'he8;
  localparam int REORDER_DIS_BIT = 15;
  localparam int RSVD14_BIT = 14;
  localparam int THRESH_LSB = 12;
  localparam int THRESH_W = 2;
  localparam logic [1:0] THRESH_RESET = 2'h1;
  localparam logic [3:0] RETRY_RESET = 4'h0;
  // ----------------------------------------
  // Threshold codes and byte levels
  // ----------------------------------------
  localparam logic [1:0] THR_SAF = 2'h0;
  localparam logic [1:0] THR_1K7 = 2'h1;
  localparam logic [1:0] THR_1K = 2'h2;
  localparam logic [1:0] THR_512 = 2'h3;
  localparam int CNT_W = 12;
  localparam logic [11:0] LVL_2K = 12'h800;
  localparam logic [11:0] LVL_1K7 = 12'h6c0;
  localparam logic [11:0] LVL_1K = 12'h400;
  localparam logic [11:0] LVL_512 = 12'h200;
  typedef enum logic [1:0] {ATF_IDLE, ATF_FILL, ATF_SEND} atf_state_e;
endpackage : atf_pkg

// ==== rtl/atf_wb_slave.sv ====
`timescale 1ns/100ps
module atf_wb_slave import atf_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cyc,
  input wire logic i_stb,
  input wire logic i_we,
  input wire logic [7:0] i_adr,
  input wire logic [3:0] i_sel,
  input wire logic [31:0] i_dat,
  input wire logic [31:0] i_status,
  output logic [31:0] o_dat,
  output logic o_ack,
  output logic o_reorder_dis,
  output logic o_rsvd14,
  output logic [1:0] o_thresh,
  output logic [3:0] o_retries,
  output logic o_gate
);
  logic req;
  logic [31:0] lec;
  assign req = i_cyc && i_stb && !o_ack;
  assign lec = {16'h0000, o_reorder_dis, o_rsvd14, o_thresh, 12'h000};

  // ----------------------------------------
  // Ack one cycle after request
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ack <= 1'b0;
    end else begin
      o_ack <= req;
    end
  end

  // ----------------------------------------
  // Writes; upper half stores only the gate bit 22
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reorder_dis <= 1'b0; // R14
      o_rsvd14 <= 1'b0; // R3
      o_thresh <= THRESH_RESET; // R5
      o_retries <= RETRY_RESET;
      o_gate <= 1'b0;
    end else if (req && i_we) begin
      if (i_adr == LEC_OFFSET && i_sel[1]) begin
        o_reorder_dis <= i_dat[REORDER_DIS_BIT]; // R2
        o_rsvd14 <= i_dat[RSVD14_BIT];
        o_thresh <= i_dat[THRESH_LSB +: THRESH_W]; // R4
      end
      if (i_adr == RETRY_OFFSET && i_sel[0]) begin
        o_retries <= i_dat[3:0];
      end
      if (i_adr == GATE_OFFSET && i_sel[2]) begin
        o_gate <= i_dat[22];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dat <= 32'h0;
    end else if (req && !i_we) begin
      unique case (i_adr)
        LEC_OFFSET: o_dat <= lec; // R1
        STAT_OFFSET: o_dat <= i_status;
        RETRY_OFFSET: o_dat <= {28'h0, o_retries};
        GATE_OFFSET: o_dat <= {9'h0, o_gate, 22'h0};
        default: o_dat <= 32'h0;
      endcase
    end
  end
endmodule : atf_wb_slave

// ==== rtl/atf_level_sel.sv ====
`timescale 1ns/100ps
module atf_level_sel import atf_pkg::*; (
  input wire logic [1:0] i_code,
  input wire logic i_saf,
  output logic [CNT_W-1:0] o_level
);
  always_comb begin
    if (i_saf) begin
      o_level = LVL_2K; // R7
    end else begin
      unique case (i_code)
        THR_SAF: o_level = LVL_2K; // R4
        THR_1K7: o_level = LVL_1K7;
        THR_1K: o_level = LVL_1K;
        THR_512: o_level = LVL_512;
      endcase
    end
  end
endmodule : atf_level_sel

// ==== bench/atf_ctrl_checker.sv ====
`timescale 1ns/100ps
module atf_ctrl_checker import atf_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic I_TX_DONE,
  input wire logic O_TX_START,
  input wire logic O_TX_ACTIVE,
  input wire logic O_UNDERRUN,
  input wire logic O_REORDER_EN
);
  // ----------------------------------------
  // Port checks
  // ----------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence wb_req; I_WB_CYC && I_WB_STB && !O_WB_ACK; endsequence
  sequence lec_ack; O_WB_ACK && I_WB_ADR == LEC_OFFSET; endsequence
  ack_answer_a: assert property (wb_req |=> O_WB_ACK) else $error("ack late");
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack held");
  rsvd_zero_a: assert property (lec_ack |-> O_WB_DAT[31:16] == 16'h0) else $error("upper bits set");
  start_pulse_a: assert property (O_TX_START |=> !O_TX_START) else $error("start held");
  start_active_a: assert property (O_TX_START == $rose(O_TX_ACTIVE)) else $error("start mismatch");
  underrun_a: assert property (O_UNDERRUN |-> $fell(O_TX_ACTIVE)) else $error("bad underrun");
  done_end_a: assert property (I_TX_DONE && O_TX_ACTIVE |=> !O_TX_ACTIVE) else $error("active after done");
  reset_dflt_a: assert property ($fell(I_SRST) |-> O_REORDER_EN && !O_TX_ACTIVE) else $error("reset state");
endmodule : atf_ctrl_checker

bind atf_ctrl atf_ctrl_checker i_chk (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
  .I_TX_DONE(I_TX_DONE), .O_TX_START(O_TX_START), .O_TX_ACTIVE(O_TX_ACTIVE),
  .O_UNDERRUN(O_UNDERRUN), .O_REORDER_EN(O_REORDER_EN));

// ==== bench/atf_phy_model.sv ====
`timescale 1ns/100ps
module atf_phy_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_active,
  input wire logic i_starve,
  output logic o_empty,
  output logic o_done
);
  // ----------------------------------------
  // Transmitter drain
  // ----------------------------------------
  logic [2:0] wait_r;
  // Starving drains the FIFO mid-packet
  assign o_empty = i_starve && i_active;
  always_ff @(posedge i_clk) begin
    if (i_srst || i_starve) begin
      wait_r <= 3'h0;
    end else if (i_start) begin
      wait_r <= 3'h5;
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    o_done <= !i_srst && wait_r == 3'h1;
  end
endmodule : atf_phy_model

// ==== bench/atf_ctrl_tb_top.sv ====
`timescale 1ns/100ps
module atf_ctrl_tb_top import atf_pkg::*;;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  typedef struct {logic g; logic [3:0] ret; logic dis; logic [1:0] code; int n; logic e, r;} atf_row_s;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, byt = 0, eop = 0, rty = 0, stv = 0;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rd, dat;
  logic ack, go, act, und, ren, emp, don;
  int num_errors = 0, n_tests = 0, starts = 0, unds = 0;
  atf_row_s rows[8] = '{'{0, 3, 1, 3, 600, 1, 0}, '{1, 3, 0, 0, 1800, 1, 0}, '{1, 3, 1, 1, 1728, 0, 0},
    '{1, 3, 0, 2, 1024, 0, 0}, '{1, 3, 0, 3, 512, 0, 0}, '{1, 3, 0, 3, 40, 1, 0},
    '{1, 3, 0, 3, 600, 1, 1}, '{1, 0, 0, 3, 600, 1, 0}};
  initial forever #50 clk = ~clk;
  atf_ctrl i_dut (.I_CLK(clk), .I_SRST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wd), .O_WB_DAT(dat), .O_WB_ACK(ack),
    .I_CHK_BYTE(byt), .I_CHK_EOP(eop), .I_FIFO_EMPTY(emp), .I_TX_DONE(don), .I_RETRY(rty),
    .O_TX_START(go), .O_TX_ACTIVE(act), .O_UNDERRUN(und), .O_REORDER_EN(ren));
  atf_phy_model i_phy (.i_clk(clk), .i_srst(rst), .i_start(go), .i_active(act), .i_starve(stv),
    .o_empty(emp), .o_done(don));
  always @(posedge clk) begin
    starts <= starts + (go === 1'b1);
    unds <= unds + (und === 1'b1);
  end
  task print_verdict;
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task chk32(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk32
  task wb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
    for (i = 0; i < 9 && ack !== 1'b1; i++) @(posedge clk);
    if (i == 9) begin
      num_errors++;
      print_verdict();
    end
    rd = dat;
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  task cfg(logic g, logic [3:0] ret, logic [31:0] lec);
    wb(1, GATE_OFFSET, {9'h0, g, 22'h0});
    wb(1, RETRY_OFFSET, {28'h0, ret});
    wb(1, LEC_OFFSET, lec);
    repeat (2) @(posedge clk);
  endtask : cfg
  task pkt(int n, logic e, logic r);
    int s, i;
    s = starts;
    @(posedge clk) rty <= r;
    repeat (n - 1) @(posedge clk) {rty, byt} <= 2'h1;
    @(posedge clk) byt <= 0;
    repeat (3) @(posedge clk);
    chk32("early start", s, starts);
    @(posedge clk) {byt, eop} <= {1'b1, e};
    @(posedge clk) {byt, eop} <= 2'h0;
    for (i = 0; i < 5 && starts == s; i++) @(posedge clk);
    chk32("start", s + 1, starts);
    for (i = 0; i < 20 && act !== 1'b0; i++) @(posedge clk);
  endtask : pkt
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    wb(0, LEC_OFFSET, 0);
    chk32("lec reset", 32'h1000, rd & 32'hffff_f000);
    wb(1, LEC_OFFSET, 32'hffff_b000);
    wb(0, LEC_OFFSET, 0);
    chk32("lec write", 32'hb000, rd & 32'hffff_f000);
    wb(0, 8'h00, 0);
    chk32("unmapped", 0, rd);
    foreach (rows[k]) begin
      cfg(rows[k].g, rows[k].ret, {16'h0, rows[k].dis, 1'b0, rows[k].code, 12'h0});
      chk32("reorder en", !(rows[k].dis && rows[k].g), ren);
      pkt(rows[k].n, rows[k].e, rows[k].r);
    end
    @(posedge clk) rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    wb(0, LEC_OFFSET, 0);
    chk32("lec rearm", 32'h1000, rd & 32'hffff_f000);
    cfg(1, 3, 32'h3000);
    stv <= 1;
    pkt(512, 0, 0);
    repeat (2) @(posedge clk);
    chk32("underrun", 1, unds);
    stv <= 0;
    pkt(600, 1, 0);
    print_verdict();
  end
endmodule : atf_ctrl_tb_top
